// ===== rmd_cfg.svh
// register offsets, field positions and reset values of the mode and discharge register bank
`ifndef RMD_CFG_SVH
`define RMD_CFG_SVH
`define RMD_ADDR_REG4_MODE 8'h25
`define RMD_ADDR_REG5_MODE 8'h26
`define RMD_ADDR_REG6_MODE 8'h27
`define RMD_ADDR_DIS_A 8'h40
`define RMD_MODE_BIT 1
`define RMD_MODE_RSVD_ZERO 2'h0
`define RMD_MODE_STORE_RST 6'h3D
`define RMD_REG6_RST 8'h3D
`define RMD_DIS_RST 8'h55
`define RMD_DIS_FIELD_RST 2'h1
`define RMD_DIS_FIELD_OFF 2'h0
`define RMD_DIS_FIELD_W 2
`define RMD_READ_ZERO 8'h00
`endif

// ===== rmd_pkg.sv
// types shared by the mode and discharge register bank
package rmd_pkg;
  typedef logic [7:0] rmd_byte_t;
  typedef logic [1:0] rmd_dsel_t;
  typedef logic [5:0] rmd_mode_store_t;
  typedef enum logic [1:0] {
    RMD_DIS_NONE = 2'b00,
    RMD_DIS_100  = 2'b01,
    RMD_DIS_200  = 2'b10,
    RMD_DIS_500  = 2'b11
  } rmd_dis_res_t;
endpackage : rmd_pkg

// ===== rmd_dis_if.sv
// carrier between the register bank and one discharge field channel
`timescale 1ns/1ps
interface rmd_dis_if;
  import rmd_pkg::*;
  logic      regOn;
  logic      wrEn;
  rmd_dsel_t wrVal;
  rmd_dsel_t field;
  rmd_dsel_t dischSel;
  modport bank (output regOn, output wrEn, output wrVal, input field, input dischSel);
  modport chan (input regOn, input wrEn, input wrVal, output field, output dischSel);
endinterface : rmd_dis_if

// ===== rmd_dis_chan.sv
// one 2-bit discharge field with auto-clear on regulator enable
`timescale 1ns/1ps
`include "rmd_cfg.svh"
module rmd_dis_chan (
  input  wire logic  clk_sys,
  input  wire logic  reset,
  rmd_dis_if.chan    ch
);
  import rmd_pkg::*;

  logic      onMeta_r;
  logic      onMeta_nxt;
  logic      onSync_r;
  logic      onSync_nxt;
  logic      onDly_r;
  logic      onDly_nxt;
  rmd_dsel_t field_r;
  rmd_dsel_t field_nxt;
  rmd_dsel_t sel_r;
  rmd_dsel_t sel_nxt;
  logic      onRise;

  // ----------------------------------------
  // enable synchroniser and field update
  // ----------------------------------------
  always_comb begin
    onMeta_nxt = ch.regOn;
    onSync_nxt = onMeta_r;
    onDly_nxt  = onSync_r;
    onRise     = onSync_r && !onDly_r;
    field_nxt  = field_r;
    if (onRise) begin
      field_nxt = `RMD_DIS_FIELD_OFF;
    end else if (ch.wrEn) begin
      field_nxt = ch.wrVal;
    end
    sel_nxt = onSync_r ? `RMD_DIS_FIELD_OFF : field_r;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      onMeta_r <= 1'b0;
      onSync_r <= 1'b0;
      onDly_r  <= 1'b0;
      field_r  <= `RMD_DIS_FIELD_RST;
      sel_r    <= `RMD_DIS_FIELD_RST;
    end else begin
      onMeta_r <= onMeta_nxt;
      onSync_r <= onSync_nxt;
      onDly_r  <= onDly_nxt;
      field_r  <= field_nxt;
      sel_r    <= sel_nxt;
    end
  end

  assign ch.field    = field_r;
  assign ch.dischSel = sel_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_enableRise;
    onSync_r && !onDly_r;
  endsequence

  chk_dis_autoclear: assert property (@(posedge clk_sys) disable iff (reset)
    s_enableRise |=> (field_r == `RMD_DIS_FIELD_OFF))
    else $error("discharge field not cleared on regulator enable");

  chk_dis_write: assert property (@(posedge clk_sys) disable iff (reset)
    (ch.wrEn && !(onSync_r && !onDly_r)) |=> (field_r == $past(ch.wrVal)))
    else $error("discharge field write not stored");

  chk_dis_apply: assert property (@(posedge clk_sys) disable iff (reset)
    onSync_r |=> (sel_r == `RMD_DIS_FIELD_OFF))
    else $error("discharge applied while regulator enabled");

  chk_dis_offsel: assert property (@(posedge clk_sys) disable iff (reset)
    (!onSync_r ##1 !onSync_r) |-> (sel_r == $past(field_r)))
    else $error("discharge selection not presented while disabled");
endmodule : rmd_dis_chan

// ===== rmd_regs.sv
// mode and discharge control register bank of a power management device
//
// Function
// - bit 1 of the fourth-regulator mode register chooses automatic (0) or forced PWM (1).
// - the fourth-regulator mode register at 25h resets from a variant setting, mode bit 0 or 1.
// - bit 1 of the fifth-regulator mode register chooses automatic (0) or forced PWM (1).
// - the fifth-regulator mode register at 26h resets from a variant setting, mode bit 0 or 1.
// - bit 1 of the sixth-regulator mode register resets to automatic (0), writing 1 forces PWM.
// - the sixth-regulator mode register at 27h resets to 0011 1101 on every variant.
// - bits 7 and 6 of each mode register read 0 and ignore writes; bits 5 to 0 are read/write.
// - the discharge register holds four 2-bit fields, regulator four in 7-6 down to one in 1-0.
// - when a regulator becomes enabled its discharge field is cleared to 00 over any write.
// - the discharge register at 40h is fully read/write and resets to 0101 0101.
`timescale 1ns/1ps
`include "rmd_cfg.svh"
module rmd_regs #(
  parameter logic REG4_PWM_RST = 1'b0,
  parameter logic REG5_PWM_RST = 1'b0,
  parameter int   NUM_DIS      = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  input  wire rmd_pkg::rmd_byte_t regAddr,
  input  wire rmd_pkg::rmd_byte_t regWrData,
  output rmd_pkg::rmd_byte_t     regRdData,
  output logic                   regRdValid,
  input  wire logic [3:0]        regOnPin,
  output logic                   reg4PwmForce,
  output logic                   reg5PwmForce,
  output logic                   reg6PwmForce,
  output rmd_pkg::rmd_dsel_t     reg1DischargeSel,
  output rmd_pkg::rmd_dsel_t     reg2DischargeSel,
  output rmd_pkg::rmd_dsel_t     reg3DischargeSel,
  output rmd_pkg::rmd_dsel_t     reg4DischargeSel
);
  import rmd_pkg::*;

  localparam rmd_mode_store_t MODE_BASE = `RMD_MODE_STORE_RST;
  localparam rmd_byte_t       REG6_FULL = `RMD_REG6_RST;
  localparam rmd_mode_store_t REG4_RST  = {MODE_BASE[5:2], REG4_PWM_RST, MODE_BASE[0]};
  localparam rmd_mode_store_t REG5_RST  = {MODE_BASE[5:2], REG5_PWM_RST, MODE_BASE[0]};

  rmd_mode_store_t mode4_r;
  rmd_mode_store_t mode4_nxt;
  rmd_mode_store_t mode5_r;
  rmd_mode_store_t mode5_nxt;
  rmd_mode_store_t mode6_r;
  rmd_mode_store_t mode6_nxt;
  rmd_byte_t       rdData_r;
  rmd_byte_t       rdData_nxt;
  logic            rdValid_r;
  logic            rdValid_nxt;
  rmd_byte_t       disAll;
  logic            disWr;

  rmd_dis_if disIf [NUM_DIS] ();

  // ----------------------------------------
  // discharge channels
  // ----------------------------------------
  assign disWr = regWrEn && (regAddr == `RMD_ADDR_DIS_A);

  for (genvar g = 0; g < NUM_DIS; g++) begin : gDis
    assign disIf[g].regOn = regOnPin[g];
    assign disIf[g].wrEn  = disWr;
    assign disIf[g].wrVal = regWrData[g*`RMD_DIS_FIELD_W +: `RMD_DIS_FIELD_W];
    assign disAll[g*`RMD_DIS_FIELD_W +: `RMD_DIS_FIELD_W] = disIf[g].field;
    rmd_dis_chan uChan (
      .clk_sys (clk_sys),
      .reset   (reset),
      .ch      (disIf[g])
    );
  end

  // ----------------------------------------
  // mode registers and read path
  // ----------------------------------------
  always_comb begin
    mode4_nxt   = mode4_r;
    mode5_nxt   = mode5_r;
    mode6_nxt   = mode6_r;
    rdValid_nxt = regRdEn;
    rdData_nxt  = rdData_r;
    if (regWrEn) begin
      if (regAddr == `RMD_ADDR_REG4_MODE) begin
        mode4_nxt = regWrData[5:0];
      end else if (regAddr == `RMD_ADDR_REG5_MODE) begin
        mode5_nxt = regWrData[5:0];
      end else if (regAddr == `RMD_ADDR_REG6_MODE) begin
        mode6_nxt = regWrData[5:0];
      end
    end
    if (regRdEn) begin
      if (regAddr == `RMD_ADDR_REG4_MODE) begin
        rdData_nxt = {`RMD_MODE_RSVD_ZERO, mode4_r};
      end else if (regAddr == `RMD_ADDR_REG5_MODE) begin
        rdData_nxt = {`RMD_MODE_RSVD_ZERO, mode5_r};
      end else if (regAddr == `RMD_ADDR_REG6_MODE) begin
        rdData_nxt = {`RMD_MODE_RSVD_ZERO, mode6_r};
      end else if (regAddr == `RMD_ADDR_DIS_A) begin
        rdData_nxt = disAll;
      end else begin
        rdData_nxt = `RMD_READ_ZERO;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode4_r   <= REG4_RST;
      mode5_r   <= REG5_RST;
      mode6_r   <= REG6_FULL[5:0];
      rdData_r  <= `RMD_READ_ZERO;
      rdValid_r <= 1'b0;
    end else begin
      mode4_r   <= mode4_nxt;
      mode5_r   <= mode5_nxt;
      mode6_r   <= mode6_nxt;
      rdData_r  <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign regRdData        = rdData_r;
  assign regRdValid       = rdValid_r;
  assign reg4PwmForce     = mode4_r[`RMD_MODE_BIT];
  assign reg5PwmForce     = mode5_r[`RMD_MODE_BIT];
  assign reg6PwmForce     = mode6_r[`RMD_MODE_BIT];
  assign reg1DischargeSel = disIf[0].dischSel;
  assign reg2DischargeSel = disIf[1].dischSel;
  assign reg3DischargeSel = disIf[2].dischSel;
  assign reg4DischargeSel = disIf[3].dischSel;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic resetSeen_r;
  always_ff @(posedge clk_sys) begin
    resetSeen_r <= reset;
  end

  sequence s_wrMode4;
    regWrEn && regAddr == `RMD_ADDR_REG4_MODE;
  endsequence

  sequence s_rdMode;
    regRdEn && (regAddr == `RMD_ADDR_REG4_MODE || regAddr == `RMD_ADDR_REG5_MODE ||
                regAddr == `RMD_ADDR_REG6_MODE);
  endsequence

  chk_mode4_write: assert property (@(posedge clk_sys) disable iff (reset)
    s_wrMode4 |=> (reg4PwmForce == $past(regWrData[`RMD_MODE_BIT])))
    else $error("fourth regulator mode bit not written");

  chk_mode5_write: assert property (@(posedge clk_sys) disable iff (reset)
    (regWrEn && regAddr == `RMD_ADDR_REG5_MODE) |=> (reg5PwmForce == $past(regWrData[`RMD_MODE_BIT])))
    else $error("fifth regulator mode bit not written");

  chk_mode6_write: assert property (@(posedge clk_sys) disable iff (reset)
    (regWrEn && regAddr == `RMD_ADDR_REG6_MODE) |=> (reg6PwmForce == $past(regWrData[`RMD_MODE_BIT])))
    else $error("sixth regulator mode bit not written");

  chk_mode_reset: assert property (@(posedge clk_sys)
    (resetSeen_r && !reset) |-> (mode6_r == `RMD_MODE_STORE_RST && !reg6PwmForce &&
                                  reg4PwmForce == REG4_PWM_RST && reg5PwmForce == REG5_PWM_RST))
    else $error("mode register reset value wrong");

  chk_mode_rsvd: assert property (@(posedge clk_sys) disable iff (reset)
    s_rdMode |=> (regRdValid && regRdData[7:6] == `RMD_MODE_RSVD_ZERO))
    else $error("reserved mode bits not reading zero");

  chk_dis_reset: assert property (@(posedge clk_sys)
    (resetSeen_r && !reset) |-> (disAll == `RMD_DIS_RST))
    else $error("discharge register reset value wrong");

  chk_dis_read: assert property (@(posedge clk_sys) disable iff (reset)
    (regRdEn && regAddr == `RMD_ADDR_DIS_A) |=> (regRdData == $past(disAll)))
    else $error("discharge register read mismatch");

  chk_mode4_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !(regWrEn && regAddr == `RMD_ADDR_REG4_MODE) |=> $stable(mode4_r))
    else $error("fourth regulator mode register changed without a write");

  sequence s_rdUnmapped;
    regRdEn && !(regAddr inside {`RMD_ADDR_REG4_MODE, `RMD_ADDR_REG5_MODE, `RMD_ADDR_REG6_MODE,
                                 `RMD_ADDR_DIS_A});
  endsequence

  chk_mode5_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !(regWrEn && regAddr == `RMD_ADDR_REG5_MODE) |=> $stable(mode5_r))
    else $error("fifth regulator mode register changed without a write");

  chk_mode6_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !(regWrEn && regAddr == `RMD_ADDR_REG6_MODE) |=> $stable(mode6_r))
    else $error("sixth regulator mode register changed without a write");

  chk_mode4_store: assert property (@(posedge clk_sys) disable iff (reset)
    s_wrMode4 |=> (mode4_r == $past(regWrData[5:0])))
    else $error("fourth regulator mode bits 5 to 0 not stored");

  chk_mode5_store: assert property (@(posedge clk_sys) disable iff (reset)
    (regWrEn && regAddr == `RMD_ADDR_REG5_MODE) |=> (mode5_r == $past(regWrData[5:0])))
    else $error("fifth regulator mode bits 5 to 0 not stored");

  chk_mode6_store: assert property (@(posedge clk_sys) disable iff (reset)
    (regWrEn && regAddr == `RMD_ADDR_REG6_MODE) |=> (mode6_r == $past(regWrData[5:0])))
    else $error("sixth regulator mode bits 5 to 0 not stored");

  chk_rd_valid: assert property (@(posedge clk_sys) disable iff (reset)
    regRdEn |=> regRdValid)
    else $error("read not answered in the next cycle");

  chk_rd_idle: assert property (@(posedge clk_sys) disable iff (reset)
    !regRdEn |=> (!regRdValid && $stable(regRdData)))
    else $error("read port changed without a read");

  chk_rd_unmapped: assert property (@(posedge clk_sys) disable iff (reset)
    s_rdUnmapped |=> (regRdData == `RMD_READ_ZERO))
    else $error("unmapped read not zero");
endmodule : rmd_regs

// ===== rmd_host_model.sv
// host model driving the register port one byte at a time
`timescale 1ns/1ps
module rmd_host_model (
  input  wire logic               clk_sys,
  output logic                    regWrEn,
  output logic                    regRdEn,
  output rmd_pkg::rmd_byte_t      regAddr,
  output rmd_pkg::rmd_byte_t      regWrData,
  input  wire rmd_pkg::rmd_byte_t regRdData,
  input  wire logic               regRdValid
);
  import rmd_pkg::*;
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'hA5;
    regWrData = 8'h5A;
  end
  // idle bus shows the inverse of the last value
  task automatic idle();
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = ~regAddr;
    regWrData = ~regWrData;
  endtask : idle
  task automatic wr(input rmd_byte_t a, input rmd_byte_t d);
    @(posedge clk_sys);
    #1;
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(posedge clk_sys);
    #1;
    idle();
  endtask : wr
  task automatic rd(input rmd_byte_t a, output rmd_byte_t d, output logic v);
    @(posedge clk_sys);
    #1;
    regRdEn = 1'b1;
    regAddr = a;
    @(posedge clk_sys);
    #1;
    d = regRdData;
    v = regRdValid;
    idle();
  endtask : rd
endmodule : rmd_host_model

// ===== tb_rmd_regs.sv
// self-checking bench of the mode and discharge register bank
`timescale 1ns/1ps
`include "rmd_cfg.svh"
module tb_rmd_regs;
  import rmd_pkg::*;
  logic      clk_sys = 1'b0;
  logic      reset = 1'b1;
  logic      regWrEn, regRdEn, regRdValid, reg4PwmForce, reg5PwmForce, reg6PwmForce;
  rmd_byte_t regAddr, regWrData, regRdData;
  logic [3:0] regOnPin = 4'h0;
  rmd_dsel_t reg1DischargeSel, reg2DischargeSel, reg3DischargeSel, reg4DischargeSel;
  int        err_total = 0;
  int        samples_checked = 0;
  int        cycles = 0;
  always #12.5 clk_sys = ~clk_sys;
  rmd_regs #(.REG4_PWM_RST(1'b0), .REG5_PWM_RST(1'b1)) rmd_regs_inst (
    .clk_sys(clk_sys), .reset(reset), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid), .regOnPin(regOnPin),
    .reg4PwmForce(reg4PwmForce), .reg5PwmForce(reg5PwmForce), .reg6PwmForce(reg6PwmForce),
    .reg1DischargeSel(reg1DischargeSel), .reg2DischargeSel(reg2DischargeSel),
    .reg3DischargeSel(reg3DischargeSel), .reg4DischargeSel(reg4DischargeSel));
  rmd_host_model rmd_host_model_inst (
    .clk_sys(clk_sys), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string name, input rmd_byte_t seen, input rmd_byte_t exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic rdchk(input rmd_byte_t a, input rmd_byte_t exp);
    rmd_byte_t d;
    logic      v;
    rmd_host_model_inst.rd(a, d, v);
    check("regRdValid", {7'h00, v}, 8'h01);
    check("regRdData", d, exp);
  endtask : rdchk
  function automatic rmd_byte_t sels();
    return {reg4DischargeSel, reg3DischargeSel, reg2DischargeSel, reg1DischargeSel};
  endfunction : sels
  function automatic rmd_byte_t modes();
    return {5'h00, reg6PwmForce, reg5PwmForce, reg4PwmForce};
  endfunction : modes
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset();
    rdchk(`RMD_ADDR_REG4_MODE, 8'h3D);
    rdchk(`RMD_ADDR_REG5_MODE, 8'h3F);
    rdchk(`RMD_ADDR_REG6_MODE, 8'h3D);
    rdchk(`RMD_ADDR_DIS_A, 8'h55);
    check("modes", modes(), 8'h02);
    check("sels", sels(), 8'h55);
  endtask : test_reset
  task automatic test_mode();
    for (int i = 0; i < 3; i++) begin
      rmd_host_model_inst.wr(8'h25 + 8'(i), 8'hC2);
      rdchk(8'h25 + 8'(i), 8'h02);
    end
    check("modes", modes(), 8'h07);
    for (int i = 0; i < 3; i++) begin
      rmd_host_model_inst.wr(8'h25 + 8'(i), 8'hFD);
      rdchk(8'h25 + 8'(i), 8'h3D);
    end
    check("modes", modes(), 8'h00);
  endtask : test_mode
  task automatic test_disch();
    rmd_byte_t vals[2] = '{8'hE4, 8'h1B};
    foreach (vals[i]) begin
      rmd_host_model_inst.wr(`RMD_ADDR_DIS_A, vals[i]);
      rdchk(`RMD_ADDR_DIS_A, vals[i]);
      check("sels", sels(), vals[i]);
    end
  endtask : test_disch
  task automatic test_enable();
    rmd_host_model_inst.wr(`RMD_ADDR_DIS_A, 8'hFF);
    regOnPin = 4'h4;
    repeat (4) @(posedge clk_sys);
    #1;
    check("sels", sels(), 8'hCF);
    rdchk(`RMD_ADDR_DIS_A, 8'hCF);
    rmd_host_model_inst.wr(`RMD_ADDR_DIS_A, 8'hFF);
    rdchk(`RMD_ADDR_DIS_A, 8'hFF);
    check("sels", sels(), 8'hCF);
    regOnPin = 4'h0;
    repeat (4) @(posedge clk_sys);
    #1;
    check("sels", sels(), 8'hFF);
  endtask : test_enable
  task automatic test_unmapped();
    rmd_host_model_inst.wr(8'h41, 8'h00);
    rmd_host_model_inst.wr(8'h24, 8'h00);
    rdchk(8'h41, 8'h00);
    rdchk(8'h24, 8'h00);
    rdchk(`RMD_ADDR_DIS_A, 8'hFF);
    rdchk(`RMD_ADDR_REG4_MODE, 8'h3D);
  endtask : test_unmapped
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    test_reset();
    test_mode();
    test_disch();
    test_enable();
    test_unmapped();
    finish_test();
  end
endmodule : tb_rmd_regs
